// ### design/irq_enable_pkg.sv
package irq_enable_pkg;

    // ==========================================================
    // sources, fields, widths
    // ==========================================================
    localparam int NUM_SRC   = 10;
    localparam int NUM_FIELD = 11;

    // field index of each enable, doubling as fault input bit for all but the global enable
    localparam int THERMAL_SHUTDOWN_IRQ_ENABLE           = 0;
    localparam int CURRENT_RESISTOR_SHORT_IRQ_ENABLE     = 1;
    localparam int STRING_CONFIG_RESISTOR_IRQ_ENABLE     = 2;
    localparam int MODE_RESISTOR_MISSING_IRQ_ENABLE      = 3;
    localparam int FREQUENCY_RESISTOR_MISSING_IRQ_ENABLE = 4;
    localparam int CONVERTER_OVERCURRENT_IRQ_ENABLE      = 5;
    localparam int CONVERTER_OVERVOLTAGE_IRQ_ENABLE      = 6;
    localparam int BUS_TIMEOUT_IRQ_ENABLE                = 7;
    localparam int INVALID_STRING_IRQ_ENABLE             = 8;
    localparam int STRING_FAULT_IRQ_ENABLE_ALIAS         = 9;
    localparam int GLOBAL_IRQ_ENABLE                     = 10;

    // upper bit of each 2-bit field, in field index order
    localparam int FIELD_HI [NUM_FIELD] = '{
        15,
        13,
        11,
        9,
        7,
        5,
        3,
        5,
        3,
        1,
        7
    };
    // one where the field lives in the LED register
    localparam logic [NUM_FIELD-1:0] FIELD_IN_LED = 11'h780;

    // ==========================================================
    // register map (index; byte address is four times it)
    // ==========================================================
    localparam logic [7:0] BOOST_IDX  = 8'h0A;
    localparam logic [7:0] LED_IDX    = 8'h0C;
    localparam logic [7:0] STATUS_IDX = 8'h10;
    localparam logic [7:0] MASK_IDX   = 8'h11;

    // ==========================================================
    // reset values and field codes
    // ==========================================================
    localparam logic [15:0]        BOOST_RESET = 16'hA028;
    localparam logic [15:0]        LED_RESET   = 16'h00AA;
    localparam logic [NUM_SRC-1:0] MASK_RESET  = 10'h3FF;
    localparam logic [1:0]         CODE_DISABLE = 2'h1;
    localparam logic [1:0]         CODE_ENABLE  = 2'h3;

endpackage

// ### design/enable_field.sv
`timescale 1ns/1ps
module enable_field #(
    parameter logic RESET_ON = 1'b0
) (
    input  wire logic       mclk,
    input  wire logic       nrst,
    input  wire logic       wrStb,
    input  wire logic [1:0] wrCode,
    output logic            isOn
);
    import irq_enable_pkg::*;

    typedef struct packed {
        logic on;
    } field_t;

    field_t q;
    field_t d;

    // ==========================================================
    // write codes
    // ==========================================================
    // only the two odd codes act, so one write may touch some fields
    always_comb
    begin
        d = q;
        if (wrStb)
        begin
            if (wrCode == CODE_DISABLE)
                d.on = 1'b0;
            else if (wrCode == CODE_ENABLE)
                d.on = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            q <= '{on: RESET_ON};
        else
            q <= d;
    end

    assign isOn = q.on;

    // ==========================================================
    // checks
    // ==========================================================
    a_code_hold: assert property (
        @(posedge mclk) disable iff (!nrst)
        (wrStb && !wrCode[0]) |=> $stable(isOn))
        else $error("even write code changed an enable");
    a_code_off: assert property (
        @(posedge mclk) disable iff (!nrst)
        (wrStb && wrCode == CODE_DISABLE) |=> !isOn)
        else $error("disable code left the enable set");

endmodule

// ### design/sticky_status.sv
`timescale 1ns/1ps
module sticky_status #(
    parameter int N = 10
) (
    input  wire logic         mclk,
    input  wire logic         nrst,
    input  wire logic [N-1:0] setVec,
    input  wire logic [N-1:0] clrVec,
    output logic      [N-1:0] status
);
    import irq_enable_pkg::*;

    typedef struct packed {
        logic [N-1:0] bits;
    } sticky_t;

    sticky_t q;
    sticky_t d;

    // ==========================================================
    // set beats clear
    // ==========================================================
    always_comb
    begin
        d      = q;
        d.bits = (q.bits & ~clrVec) | setVec;
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            q <= '0;
        else
            q <= d;
    end

    assign status = q.bits;

    a_set_wins: assert property (
        @(posedge mclk) disable iff (!nrst)
        (setVec != '0) |=> ((status & $past(setVec)) == $past(setVec)))
        else $error("fault event lost in status");

endmodule

// ### design/fault_interrupt_enable_regs.sv
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
module fault_interrupt_enable_regs (
    input  wire logic                             mclk,
    input  wire logic                             nrst,
    input  wire logic [7:0]                       address,
    input  wire logic                             read,
    input  wire logic                             write,
    input  wire logic [3:0]                       byteenable,
    input  wire logic [31:0]                      writedata,
    output logic      [31:0]                      readdata,
    output logic                                  waitrequest,
    input  wire logic [irq_enable_pkg::NUM_SRC-1:0] faultEvent,
    output logic                                  irqOut
);
    import irq_enable_pkg::*;

    // ==========================================================
    // state
    // ==========================================================
    typedef enum logic [0:0] {
        BUS_IDLE,
        BUS_ACK
    } busState_t;

    typedef struct packed {
        busState_t          state;
        logic               waitreq;
        logic [31:0]        rdata;
        logic [NUM_SRC-1:0] mask;
        logic               irq;
    } ctrl_t;

    ctrl_t q;
    ctrl_t d;

    // ==========================================================
    // decode
    // ==========================================================
    logic [7:0]           regIdx;
    logic                 addrOk;
    logic                 hitBoost;
    logic                 hitLed;
    logic                 hitStatus;
    logic                 hitMask;
    logic                 wrCommit;
    logic                 rdCommit;
    logic [NUM_FIELD-1:0] fieldOn;
    logic [NUM_SRC-1:0]   srcOn;
    logic [NUM_SRC-1:0]   statusVec;
    logic [NUM_SRC-1:0]   clrVec;
    logic [15:0]          boostView;
    logic [15:0]          ledView;
    logic [31:0]          readMux;
    logic                 irqCause;

    assign regIdx = {2'b00, address[7:2]};
    assign addrOk = (address[1:0] == 2'b00);

    always_comb
    begin
        hitBoost  = 1'b0;
        hitLed    = 1'b0;
        hitStatus = 1'b0;
        hitMask   = 1'b0;
        if (!addrOk)
            hitBoost = 1'b0;
        else if (regIdx == BOOST_IDX)
            hitBoost = 1'b1;
        else if (regIdx == LED_IDX)
            hitLed = 1'b1;
        else if (regIdx == STATUS_IDX)
            hitStatus = 1'b1;
        else if (regIdx == MASK_IDX)
            hitMask = 1'b1;
    end

    // the master holds its request through the ack cycle
    assign wrCommit = (q.state == BUS_ACK) && write;
    assign rdCommit = (q.state == BUS_ACK) && read;

    // ==========================================================
    // enable fields
    // ==========================================================
    generate
        for (genvar i = 0; i < NUM_FIELD; i++)
        begin : g_field
            localparam logic RST_ON = FIELD_IN_LED[i] ?
                LED_RESET[FIELD_HI[i]] : BOOST_RESET[FIELD_HI[i]];
            logic hitReg;
            logic stb;
            assign hitReg = FIELD_IN_LED[i] ? hitLed : hitBoost;
            // a field only sees its own byte lane
            assign stb = wrCommit && hitReg && byteenable[FIELD_HI[i] / 8];
            enable_field #(
                .RESET_ON (RST_ON)
            ) u_field (
                .mclk   (mclk),
                .nrst   (nrst),
                .wrStb  (stb),
                .wrCode (writedata[FIELD_HI[i] -: 2]),
                .isOn   (fieldOn[i])
            );
        end
    endgenerate

    assign srcOn = fieldOn[NUM_SRC-1:0];

    // read view: enabled shows as the upper bit of the field
    always_comb
    begin
        boostView = '0;
        ledView   = '0;
        for (int i = 0; i < NUM_FIELD; i++)
        begin
            if (FIELD_IN_LED[i])
                ledView[FIELD_HI[i]] = fieldOn[i];
            else
                boostView[FIELD_HI[i]] = fieldOn[i];
        end
    end

    // ==========================================================
    // fault status
    // ==========================================================
    // clear only what the read returned, so a fault arriving
    // between sample and completion survives
    assign clrVec = (rdCommit && hitStatus) ? q.rdata[NUM_SRC-1:0] : '0;

    sticky_status #(
        .N (NUM_SRC)
    ) u_status (
        .mclk   (mclk),
        .nrst   (nrst),
        .setVec (faultEvent),
        .clrVec (clrVec),
        .status (statusVec)
    );

    assign irqCause = fieldOn[GLOBAL_IRQ_ENABLE] &&
                      (|(statusVec & srcOn & q.mask));

    // ==========================================================
    // read mux
    // ==========================================================
    always_comb
    begin
        readMux = '0;
        if (hitBoost)
            readMux = {16'h0000, boostView};
        else if (hitLed)
            readMux = {16'h0000, ledView};
        else if (hitStatus)
            readMux = {{(32-NUM_SRC){1'b0}}, statusVec};
        else if (hitMask)
            readMux = {{(32-NUM_SRC){1'b0}}, q.mask};
    end

    // ==========================================================
    // bus and interrupt state
    // ==========================================================
    always_comb
    begin
        d     = q;
        d.irq = irqCause;
        case (q.state)
            BUS_IDLE:
            begin
                if (read || write)
                begin
                    d.state   = BUS_ACK;
                    d.waitreq = 1'b0;
                    if (read)
                        d.rdata = readMux;
                end
            end
            BUS_ACK:
            begin
                d.state   = BUS_IDLE;
                d.waitreq = 1'b1;
                if (wrCommit && hitMask)
                begin
                    if (byteenable[0])
                        d.mask[7:0] = writedata[7:0];
                    if (byteenable[1])
                        d.mask[NUM_SRC-1:8] = writedata[NUM_SRC-1:8];
                end
            end
            default:
            begin
                d.state   = BUS_IDLE;
                d.waitreq = 1'b1;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            q.state   <= BUS_IDLE;
            q.waitreq <= 1'b1;
            q.rdata   <= '0;
            q.mask    <= MASK_RESET;
            q.irq     <= 1'b0;
        end
        else
            q <= d;
    end

    assign readdata    = q.rdata;
    assign waitrequest = q.waitreq;
    assign irqOut      = q.irq;

    // ==========================================================
    // checks
    // ==========================================================
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    a_boost_read_code: assert property (
        (rdCommit && hitBoost) |->
        readdata[15:14] == {fieldOn[THERMAL_SHUTDOWN_IRQ_ENABLE], 1'b0})
        else $error("boost field read code wrong");

    a_boost_reserved: assert property (
        (rdCommit && hitBoost) |-> readdata[1:0] == 2'h0)
        else $error("boost reserved bits not zero");

    a_led_reserved: assert property (
        (rdCommit && hitLed) |-> readdata[15:8] == 8'h00)
        else $error("led reserved bits not zero");

    a_led_global_read: assert property (
        (rdCommit && hitLed) |->
        readdata[7:6] == {fieldOn[GLOBAL_IRQ_ENABLE], 1'b0})
        else $error("global enable read code wrong");

    a_enable_write: assert property (
        (wrCommit && hitBoost && byteenable[1] &&
         writedata[15:14] == CODE_ENABLE)
        |=> fieldOn[THERMAL_SHUTDOWN_IRQ_ENABLE])
        else $error("enable code did not enable");

    a_irq_gated: assert property (
        irqOut |-> $past(fieldOn[GLOBAL_IRQ_ENABLE]) &&
        (($past(statusVec) & $past(srcOn) & $past(q.mask)) != '0))
        else $error("interrupt without enabled cause");

    a_irq_follow: assert property (
        irqCause |=> irqOut)
        else $error("enabled fault did not raise interrupt");

    a_wait_release: assert property (
        !waitrequest |=> waitrequest)
        else $error("waitrequest low for more than one cycle");

    a_req_answer: assert property (
        ((read || write) && waitrequest) |-> ##[1:2] !waitrequest)
        else $error("request not answered in two cycles");

    a_current_read_code: assert property (
        (rdCommit && hitBoost) |->
        readdata[13:12] == {fieldOn[CURRENT_RESISTOR_SHORT_IRQ_ENABLE], 1'b0})
        else $error("current resistor field read code wrong");

    a_string_read_code: assert property (
        (rdCommit && hitBoost) |->
        readdata[11:10] == {fieldOn[STRING_CONFIG_RESISTOR_IRQ_ENABLE], 1'b0})
        else $error("string config field read code wrong");

    a_mode_read_code: assert property (
        (rdCommit && hitBoost) |->
        readdata[9:8] == {fieldOn[MODE_RESISTOR_MISSING_IRQ_ENABLE], 1'b0})
        else $error("mode resistor field read code wrong");

    a_freq_read_code: assert property (
        (rdCommit && hitBoost) |->
        readdata[7:6] == {fieldOn[FREQUENCY_RESISTOR_MISSING_IRQ_ENABLE], 1'b0})
        else $error("frequency resistor field read code wrong");

    a_overcurrent_read: assert property (
        (rdCommit && hitBoost) |->
        readdata[5:4] == {fieldOn[CONVERTER_OVERCURRENT_IRQ_ENABLE], 1'b0})
        else $error("overcurrent field read code wrong");

    a_overvoltage_read: assert property (
        (rdCommit && hitBoost) |->
        readdata[3:2] == {fieldOn[CONVERTER_OVERVOLTAGE_IRQ_ENABLE], 1'b0})
        else $error("overvoltage field read code wrong");

    a_timeout_read_code: assert property (
        (rdCommit && hitLed) |->
        readdata[5:4] == {fieldOn[BUS_TIMEOUT_IRQ_ENABLE], 1'b0})
        else $error("bus timeout field read code wrong");

    a_invalid_read_code: assert property (
        (rdCommit && hitLed) |->
        readdata[3:2] == {fieldOn[INVALID_STRING_IRQ_ENABLE], 1'b0})
        else $error("invalid string field read code wrong");

    a_ledfault_read_code: assert property (
        (rdCommit && hitLed) |->
        readdata[1:0] == {fieldOn[STRING_FAULT_IRQ_ENABLE_ALIAS], 1'b0})
        else $error("led fault field read code wrong");

    a_unmapped_read: assert property (
        (rdCommit && !(hitBoost || hitLed || hitStatus || hitMask)) |->
        readdata == '0)
        else $error("unmapped read returned data");

    a_status_clear: assert property (
        (rdCommit && hitStatus && faultEvent == '0) |=>
        (statusVec & $past(clrVec)) == '0)
        else $error("status read did not clear returned bits");

    a_global_gate: assert property (
        !fieldOn[GLOBAL_IRQ_ENABLE] |=> !irqOut)
        else $error("interrupt with global enable off");

    a_disabled_quiet: assert property (
        ((statusVec & srcOn & q.mask) == '0) |=> !irqOut)
        else $error("interrupt from disabled or masked source");

    a_rdata_hold: assert property (
        !(read && q.state == BUS_IDLE) |=> $stable(readdata))
        else $error("read data changed without a new read");

endmodule

// ### tb/avalon_host.sv
`timescale 1ns/1ps
module avalon_host (
    input  wire logic        mclk,
    output logic      [7:0]  address,
    output logic             read,
    output logic             write,
    output logic      [3:0]  byteenable,
    output logic      [31:0] writedata,
    input  wire logic [31:0] readdata,
    input  wire logic        waitrequest
);
    // ======================================
    // idle bus
    // ======================================
    initial
    begin
        address = 8'h00;
        read = 1'b0;
        write = 1'b0;
        byteenable = 4'h0;
        writedata = 32'h0;
    end

    // ======================================
    // one access, held until waitrequest low
    // ======================================
    // no cycle count assumed; only the bench watchdog ends a hang
    task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] be,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge mclk);
        address <= a;
        byteenable <= be;
        writedata <= d;
        write <= w;
        read <= ~w;
        do @(posedge mclk); while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        // released lines show no stale value
        address <= ~a;
        writedata <= ~d;
        byteenable <= ~be;
    endtask
endmodule

// ### tb/fault_interrupt_enable_regs_bench.sv
`timescale 1ns/1ps
module fault_interrupt_enable_regs_bench;
    import irq_enable_pkg::*;
    logic               mclk;
    logic               nrst;
    logic [7:0]         address;
    logic               read;
    logic               write;
    logic [3:0]         byteenable;
    logic [31:0]        writedata;
    logic [31:0]        readdata;
    logic               waitrequest;
    logic [NUM_SRC-1:0] faultEvent;
    logic               irqOut;
    int                 fails;
    int                 comparisons;
    bit                 en [NUM_FIELD];
    bit   [9:0]         maskM;
    logic [7:0]         addrTab [6] = '{8'h28, 8'h30, 8'h40, 8'h44, 8'h2C, 8'h29};

    fault_interrupt_enable_regs u_fault_interrupt_enable_regs (
        .mclk(mclk), .nrst(nrst), .address(address), .read(read), .write(write),
        .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .faultEvent(faultEvent), .irqOut(irqOut));

    avalon_host u_avalon_host (
        .mclk(mclk), .address(address), .read(read), .write(write),
        .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest));

    // ======================================
    // reference model
    // ======================================
    function automatic logic [31:0] regExp(int k);
        logic [31:0] v;
        v = 32'h0;
        if (k < 2)
        begin
            for (int f = 0; f < NUM_FIELD; f++)
                if (FIELD_IN_LED[f] == (k == 1)) v[FIELD_HI[f]] = en[f];
        end
        else if (k == 3) v[9:0] = maskM;
        return v;
    endfunction

    task automatic modelWrite(int k, logic [31:0] d, logic [3:0] be);
        int hi;
        if (k < 2)
        begin
            for (int f = 0; f < NUM_FIELD; f++)
            begin
                hi = FIELD_HI[f];
                if (FIELD_IN_LED[f] == (k == 1) && be[hi/8])
                begin
                    if (d[hi-:2] == 2'h1) en[f] = 1'b0;
                    if (d[hi-:2] == 2'h3) en[f] = 1'b1;
                end
            end
        end
        else if (k == 3)
        begin
            for (int i = 0; i < 10; i++)
                if (be[i/8]) maskM[i] = d[i];
        end
    endtask

    // ======================================
    // compare and verdict
    // ======================================
    task automatic chk(logic [31:0] seen, logic [31:0] exp, string msg);
        comparisons++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("fails %0d comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // sized for about six times the expected run
    initial
    begin
        repeat (12000) @(posedge mclk);
        fails++;
        end_of_test();
    end

    // ======================================
    // tests
    // ======================================
    initial
    begin
        logic [31:0] q;
        logic [31:0] d;
        logic [3:0]  be;
        int          k;
        int          s;
        logic        e;
        nrst = 1'b0;
        faultEvent = '0;
        void'($urandom(32'hD4F62985));
        // second pass resets in mid-run, after random writes moved the enables
        for (int r = 0; r < 2; r++)
        begin
            nrst <= 1'b0;
            en = '{1, 1, 0, 0, 0, 1, 1, 1, 1, 1, 1};
            maskM = 10'h3FF;
            repeat (20) @(posedge mclk);
            nrst <= 1'b1;
            @(posedge mclk);
            chk({31'h0, waitrequest}, 32'h1, "idle waitrequest");
            chk({31'h0, irqOut}, 32'h0, "irq after reset");
            for (k = 0; k < 6; k++)
            begin
                u_avalon_host.xfer(1'b0, addrTab[k], 4'hF, 32'h0, q);
                chk(q, regExp(k), "reset value");
            end
            // random codes hit all four field values, lanes hit partial writes
            for (int n = 0; n < 60; n++)
            begin
                k = $urandom_range(5);
                d = $urandom;
                be = 4'($urandom);
                u_avalon_host.xfer(1'b1, addrTab[k], be, d, q);
                modelWrite(k, d, be);
                u_avalon_host.xfer(1'b0, addrTab[k], 4'hF, 32'h0, q);
                chk(q, regExp(k), "readback");
                s = $urandom_range(NUM_SRC - 1);
                @(posedge mclk);
                faultEvent <= NUM_SRC'(1) << s;
                @(posedge mclk);
                faultEvent <= '0;
                repeat (3) @(posedge mclk);
                e = en[s] & en[GLOBAL_IRQ_ENABLE] & maskM[s];
                chk({31'h0, irqOut}, {31'h0, e}, "irq");
                u_avalon_host.xfer(1'b0, 8'h40, 4'hF, 32'h0, q);
                chk(q, 32'h1 << s, "status");
                repeat (2) @(posedge mclk);
                chk({31'h0, irqOut}, 32'h0, "irq after clear");
            end
        end
        end_of_test();
    end
endmodule
